/* shared/usbep0_pkg.sv */
// usbep0_pkg: constants, field layout and carriers of the endpoint 0 block
package usbep0_pkg;

	// ******************************
	// register offsets
	// ******************************
	localparam logic [7:0] OFS_INDEX = 8'h0e;
	localparam logic [7:0] OFS_TX_MAX_PACKET = 8'h10;
	localparam logic [7:0] OFS_EP0_CONTROL_STATUS = 8'h12;
	localparam logic [7:0] OFS_EP0_RX_BYTE_COUNT = 8'h18;
	localparam logic [7:0] OFS_EP0_NAK_TIMEOUT_LIMIT = 8'h1b;
	localparam logic [7:0] OFS_CORE_CONFIG_INFO = 8'h1f;

	// ******************************
	// control/status field positions
	// ******************************
	localparam int BIT_PING_OFF = 11;
	localparam int BIT_FIFO_FLUSH = 8;
	localparam int BIT_SETUP_END_ACK = 7;
	localparam int BIT_NAK_TIMEOUT = 7;
	localparam int BIT_RX_PACKET_ACK = 6;
	localparam int BIT_STATUS_STAGE = 6;
	localparam int BIT_STALL_REQUEST = 5;
	localparam int BIT_IN_REQUEST = 5;
	localparam int BIT_SETUP_ABORT = 4;
	localparam int BIT_ERROR = 4;
	localparam int BIT_LAST_DATA = 3;
	localparam int BIT_SETUP_TOKEN = 3;
	localparam int BIT_STALL_SENT = 2;
	localparam int BIT_STALL_RECEIVED = 2;
	localparam int BIT_TX_LOADED = 1;
	localparam int BIT_RX_WAITING = 0;

	localparam int MAXP_LSB_MULT = 11;
	localparam logic [10:0] MAX_PAYLOAD_LIMIT = 11'h400;

	// ******************************
	// values after reset and counts
	// ******************************
	localparam logic [3:0] RST_INDEX = 4'h0;
	localparam logic [4:0] RST_NAK_LIMIT = 5'h00;
	localparam logic [15:0] RST_TX_MAX_PACKET = 16'h0000;
	localparam logic [7:0] RST_BYTE_COUNT = 8'h00;
	localparam logic [1:0] NO_RESP_ATTEMPTS = 2'h3;
	localparam logic [3:0] EP0_INDEX = 4'h0;

	// ******************************
	// link carriers
	// ******************************
	typedef struct packed {
		logic tx_done;
		logic rx_pkt;
		logic [7:0] rx_bytes;
		logic stall_tx;
		logic ctrl_end;
		logic stall_rx;
		logic no_resp;
		logic nak;
		logic resp_ok;
		logic frame_tick;
	} usbep0_evt_s;

	typedef struct packed {
		logic tx_ready;
		logic setup_token;
		logic in_go;
		logic stall_go;
		logic toggle_one;
		logic ping_off;
		logic flush;
		logic halted;
		logic [10:0] max_payload;
		logic [5:0] mult;
	} usbep0_cmd_s;

endpackage : usbep0_pkg

/* rtl/usbep0_ctrl.sv */
// usbep0_ctrl: endpoint 0 control/status registers and their link behaviour
// ******************************
// What this block does
// R1: flush drops packet, clears loaded/waiting flags
// R2: setup-end ack clears setup-abort, self-clears
// R3: receive ack clears packet-waiting, self-clears
// R4: stall request sends STALL, then self-clears
// R5: early control end: abort flag, interrupt, flush
// R6: software sets last-data mark; device clears it
// R7: stall-sent flag set after STALL, software clears
// R8: transmitted packet clears loaded bit, interrupts
// R9: arriving packet sets waiting flag, interrupts
// R10: host ping-suppress stops PING tokens
// R11: NAK run over limit halts, sets timeout
// R12: status request forces DATA1 toggle
// R13: IN request starts IN, cleared on receive
// R14: three unanswered attempts set error, interrupt
// R15: setup select sends SETUP instead of OUT
// R16: host stall-received flag sticky until cleared
// R17: host receive sets waiting flag, interrupts
// R18: read-only received byte count
// R19: read-only configuration flags
// R20: 5-bit NAK limit in frames
// R21: max payload field up to 1024 bytes
// R22: multiplier bits, effective value plus one
// R23: 4-bit index selects visible endpoint registers
// R24: role picks view; unused bits read zero
// ******************************
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module usbep0_ctrl
	import usbep0_pkg::*;
#(
	parameter bit OPT_BULK_COMBINE = 1'b0,
	parameter bit OPT_BULK_SPLIT = 1'b0,
	parameter bit OPT_BIG_ENDIAN = 1'b0,
	parameter bit OPT_HB_RX_ISO = 1'b0,
	parameter bit OPT_HB_TX_ISO = 1'b0,
	parameter bit OPT_DYNAMIC_FIFO = 1'b0,
	parameter bit OPT_SOFT_CONNECT = 1'b0,
	parameter bit OPT_PHY_WIDE = 1'b0,
	parameter bit OPT_MULT_WIDE = 1'b1
) (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire logic host_mode_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire usbep0_evt_s evt_i,
	output usbep0_cmd_s cmd_o,
	output logic ep0_irq_o
);

	// ******************************
	// decode helpers
	// ******************************
	function automatic logic hit(input logic [7:0] ofs);
		hit = (addr_i == ofs);
	endfunction : hit

	function automatic logic [15:0] maxp_mask(input logic wide);
		if (!(OPT_HB_TX_ISO || OPT_BULK_SPLIT))
			maxp_mask = 16'h07ff;
		else if (wide)
			maxp_mask = 16'hffff;
		else
			maxp_mask = 16'h1fff;
	endfunction : maxp_mask

	logic [3:0] index_reg;
	logic [4:0] nak_limit_reg;
	logic [15:0] tx_max_packet_reg;
	logic [7:0] byte_count_reg;
	logic setup_abort_reg, stall_request_reg, last_data_reg, stall_sent_reg;
	logic tx_loaded_reg, rx_waiting_reg;
	logic ping_off_reg, nak_timeout_reg, status_stage_reg, in_request_reg;
	logic error_reg, setup_token_reg, stall_received_reg;
	logic nak_run_reg;
	logic [4:0] nak_frames_reg;
	logic [1:0] attempts_reg;
	logic [15:0] rdata_reg;
	logic irq_reg;
	usbep0_cmd_s cmd_reg;

	logic ep0_sel, csr_wr, flush_wr, early_end, err_hit, nak_hit;
	logic [15:0] csr_view;

	assign ep0_sel = (index_reg == EP0_INDEX);
	assign csr_wr = wr_i && hit(OFS_EP0_CONTROL_STATUS) && ep0_sel; // R23
	assign flush_wr = csr_wr && wdata_i[BIT_FIFO_FLUSH];
	assign early_end = !host_mode_i && evt_i.ctrl_end && !last_data_reg; // R5
	assign err_hit = host_mode_i && evt_i.no_resp && (attempts_reg == NO_RESP_ATTEMPTS - 2'h1);
	assign nak_hit = host_mode_i && nak_run_reg && evt_i.frame_tick && (nak_limit_reg != 5'h00)
		&& (nak_frames_reg + 5'h01 >= nak_limit_reg);

	// ******************************
	// index and plain registers
	// ******************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			index_reg <= RST_INDEX;
			nak_limit_reg <= RST_NAK_LIMIT;
			tx_max_packet_reg <= RST_TX_MAX_PACKET;
		end else if (wr_i) begin
			if (hit(OFS_INDEX))
				index_reg <= wdata_i[3:0]; // R23
			if (hit(OFS_EP0_NAK_TIMEOUT_LIMIT))
				nak_limit_reg <= wdata_i[4:0]; // R20
			if (hit(OFS_TX_MAX_PACKET) && ep0_sel) begin
				// payload clamps at the largest legal size
				if (wdata_i[10:0] > MAX_PAYLOAD_LIMIT)
					tx_max_packet_reg <= {wdata_i[15:11], MAX_PAYLOAD_LIMIT}
						& maxp_mask(OPT_MULT_WIDE); // R21 R22
				else
					tx_max_packet_reg <= wdata_i & maxp_mask(OPT_MULT_WIDE); // R21 R22
			end
		end
	end

	// ******************************
	// received byte count
	// ******************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			byte_count_reg <= RST_BYTE_COUNT;
		else if (evt_i.rx_pkt)
			byte_count_reg <= evt_i.rx_bytes; // R18
		else if (flush_wr || early_end)
			byte_count_reg <= RST_BYTE_COUNT; // R1
	end

	// ******************************
	// shared packet flags
	// ******************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_loaded_reg <= 1'b0;
			rx_waiting_reg <= 1'b0;
		end else begin
			if (csr_wr && wdata_i[BIT_TX_LOADED] && !flush_wr)
				tx_loaded_reg <= 1'b1;
			else if (evt_i.tx_done || flush_wr || early_end || err_hit)
				tx_loaded_reg <= 1'b0; // R8 R1 R14
			if (evt_i.rx_pkt)
				rx_waiting_reg <= 1'b1; // R9 R17
			else if (flush_wr || early_end)
				rx_waiting_reg <= 1'b0; // R1
			else if (csr_wr && !host_mode_i && wdata_i[BIT_RX_PACKET_ACK])
				rx_waiting_reg <= 1'b0; // R3
			else if (csr_wr && host_mode_i && !wdata_i[BIT_RX_WAITING])
				rx_waiting_reg <= 1'b0; // R17
		end
	end

	// ******************************
	// peripheral-mode flags
	// ******************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			setup_abort_reg <= 1'b0;
			stall_request_reg <= 1'b0;
			last_data_reg <= 1'b0;
			stall_sent_reg <= 1'b0;
		end else begin
			if (early_end)
				setup_abort_reg <= 1'b1; // R5
			else if (csr_wr && !host_mode_i && wdata_i[BIT_SETUP_END_ACK])
				setup_abort_reg <= 1'b0; // R2
			if (!host_mode_i && evt_i.stall_tx)
				stall_request_reg <= 1'b0; // R4
			else if (csr_wr && !host_mode_i && wdata_i[BIT_STALL_REQUEST])
				stall_request_reg <= 1'b1; // R4
			if (evt_i.ctrl_end)
				last_data_reg <= 1'b0; // R6
			else if (csr_wr && !host_mode_i && wdata_i[BIT_LAST_DATA])
				last_data_reg <= 1'b1; // R6
			if (!host_mode_i && evt_i.stall_tx)
				stall_sent_reg <= 1'b1; // R7
			else if (csr_wr && !host_mode_i && !wdata_i[BIT_STALL_SENT])
				stall_sent_reg <= 1'b0; // R7
		end
	end

	// ******************************
	// host-mode flags
	// ******************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ping_off_reg <= 1'b0;
			status_stage_reg <= 1'b0;
			in_request_reg <= 1'b0;
			setup_token_reg <= 1'b0;
			error_reg <= 1'b0;
			stall_received_reg <= 1'b0;
			nak_timeout_reg <= 1'b0;
		end else begin
			if (csr_wr && host_mode_i) begin
				ping_off_reg <= wdata_i[BIT_PING_OFF]; // R10
				status_stage_reg <= wdata_i[BIT_STATUS_STAGE]; // R12
				setup_token_reg <= wdata_i[BIT_SETUP_TOKEN]; // R15
			end
			if (host_mode_i && (evt_i.rx_pkt || err_hit))
				in_request_reg <= 1'b0; // R13
			else if (csr_wr && host_mode_i)
				in_request_reg <= wdata_i[BIT_IN_REQUEST]; // R13
			if (err_hit)
				error_reg <= 1'b1; // R14
			else if (csr_wr && host_mode_i && !wdata_i[BIT_ERROR])
				error_reg <= 1'b0; // R14
			if (host_mode_i && evt_i.stall_rx)
				stall_received_reg <= 1'b1; // R16
			else if (csr_wr && host_mode_i && !wdata_i[BIT_STALL_RECEIVED])
				stall_received_reg <= 1'b0; // R16
			if (nak_hit)
				nak_timeout_reg <= 1'b1; // R11
			else if (csr_wr && host_mode_i && !wdata_i[BIT_NAK_TIMEOUT])
				nak_timeout_reg <= 1'b0; // R11
		end
	end

	// ******************************
	// attempt and NAK counters
	// ******************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			attempts_reg <= 2'h0;
			nak_run_reg <= 1'b0;
			nak_frames_reg <= 5'h00;
		end else begin
			if (evt_i.resp_ok || err_hit || !host_mode_i)
				attempts_reg <= 2'h0;
			else if (evt_i.no_resp)
				attempts_reg <= attempts_reg + 2'h1; // R14
			if (evt_i.resp_ok || nak_hit || !host_mode_i) begin
				nak_run_reg <= 1'b0;
				nak_frames_reg <= 5'h00;
			end else begin
				if (evt_i.nak)
					nak_run_reg <= 1'b1;
				if (nak_run_reg && evt_i.frame_tick)
					nak_frames_reg <= nak_frames_reg + 5'h01; // R20
			end
		end
	end

	// ******************************
	// read path
	// ******************************
	always_comb begin
		csr_view = 16'h0000; // R24
		if (host_mode_i) begin
			csr_view[BIT_PING_OFF] = ping_off_reg;
			csr_view[BIT_NAK_TIMEOUT] = nak_timeout_reg;
			csr_view[BIT_STATUS_STAGE] = status_stage_reg;
			csr_view[BIT_IN_REQUEST] = in_request_reg;
			csr_view[BIT_ERROR] = error_reg;
			csr_view[BIT_SETUP_TOKEN] = setup_token_reg;
			csr_view[BIT_STALL_RECEIVED] = stall_received_reg;
		end else begin
			csr_view[BIT_STALL_REQUEST] = stall_request_reg;
			csr_view[BIT_SETUP_ABORT] = setup_abort_reg;
			csr_view[BIT_LAST_DATA] = last_data_reg;
			csr_view[BIT_STALL_SENT] = stall_sent_reg;
		end
		csr_view[BIT_TX_LOADED] = tx_loaded_reg;
		csr_view[BIT_RX_WAITING] = rx_waiting_reg;
	end

	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i)
			rdata_reg <= 16'h0000;
		else if (rd_i) begin
			case (addr_i)
				OFS_INDEX: rdata_reg <= {12'h000, index_reg};
				OFS_EP0_CONTROL_STATUS: rdata_reg <= ep0_sel ? csr_view : 16'h0000; // R23 R24
				OFS_EP0_RX_BYTE_COUNT: rdata_reg <= ep0_sel ? {8'h00, byte_count_reg} : 16'h0000;
				OFS_TX_MAX_PACKET: rdata_reg <= ep0_sel ? tx_max_packet_reg : 16'h0000;
				OFS_EP0_NAK_TIMEOUT_LIMIT: rdata_reg <= {11'h000, nak_limit_reg};
				OFS_CORE_CONFIG_INFO: rdata_reg <= {8'h00, OPT_BULK_COMBINE, OPT_BULK_SPLIT,
					OPT_BIG_ENDIAN, OPT_HB_RX_ISO, OPT_HB_TX_ISO, OPT_DYNAMIC_FIFO,
					OPT_SOFT_CONNECT, OPT_PHY_WIDE}; // R19
				default: rdata_reg <= 16'h0000;
			endcase
		end else
			rdata_reg <= 16'h0000;
	end

	// ******************************
	// link commands and event pulse
	// ******************************
	always_ff @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			// halted endpoint starts no OUT or IN transfer (tx_ready, in_go held low) until the timeout flag is cleared
			cmd_reg.tx_ready <= tx_loaded_reg && !(host_mode_i && nak_timeout_reg); // R11
			cmd_reg.in_go <= host_mode_i && in_request_reg && !nak_timeout_reg; // R13 R11
			cmd_reg.setup_token <= host_mode_i && setup_token_reg && tx_loaded_reg; // R15
			cmd_reg.stall_go <= !host_mode_i && stall_request_reg; // R4
			cmd_reg.toggle_one <= host_mode_i && status_stage_reg
				&& (tx_loaded_reg || in_request_reg); // R12
			cmd_reg.ping_off <= host_mode_i && ping_off_reg; // R10
			cmd_reg.flush <= flush_wr || early_end || err_hit; // R1 R5
			cmd_reg.halted <= host_mode_i && nak_timeout_reg; // R11
			cmd_reg.max_payload <= tx_max_packet_reg[10:0]; // R21
			cmd_reg.mult <= (OPT_HB_TX_ISO || OPT_BULK_SPLIT)
				? {1'b0, tx_max_packet_reg[15:MAXP_LSB_MULT]} + 6'h01 : 6'h01; // R22
			irq_reg <= (evt_i.tx_done && tx_loaded_reg) || evt_i.rx_pkt
				|| early_end || err_hit; // R8 R9 R5 R14 R17
		end
	end

	assign rdata_o = rdata_reg;
	assign cmd_o = cmd_reg;
	assign ep0_irq_o = irq_reg;

	// ******************************
	// checks
	// ******************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	setup_ack_clear_a: assert property (csr_wr && !host_mode_i && wdata_i[BIT_SETUP_END_ACK]
		&& !early_end |=> !setup_abort_reg) else $error("setup abort not cleared"); // R2
	early_end_flags_a: assert property (early_end |=> setup_abort_reg && ep0_irq_o
		&& cmd_o.flush) else $error("early end missed"); // R5
	stall_cycle_a: assert property (!host_mode_i && evt_i.stall_tx
		|=> stall_sent_reg && !stall_request_reg) else $error("stall not done"); // R4
	tx_done_irq_a: assert property (evt_i.tx_done && tx_loaded_reg
		|=> !tx_loaded_reg && ep0_irq_o) else $error("tx done not reported"); // R8
	rx_set_wins_a: assert property (evt_i.rx_pkt |=> rx_waiting_reg
		&& (byte_count_reg == $past(evt_i.rx_bytes))) else $error("rx flag lost"); // R9
	in_req_drop_a: assert property (host_mode_i && evt_i.rx_pkt
		|=> !in_request_reg ##1 !cmd_o.in_go) else $error("in request kept"); // R13
	error_third_a: assert property (host_mode_i && evt_i.no_resp && attempts_reg == 2'h2
		|=> error_reg && !tx_loaded_reg) else $error("error not raised"); // R14
	halt_hold_a: assert property (host_mode_i && nak_timeout_reg && $stable(host_mode_i)
		|=> cmd_o.halted && !cmd_o.in_go) else $error("halt not held"); // R11
	toggle_one_a: assert property (host_mode_i && status_stage_reg && tx_loaded_reg
		&& $stable(host_mode_i) |=> cmd_o.toggle_one) else $error("toggle not forced"); // R12
	unmapped_zero_a: assert property (rd_i && addr_i == 8'hff |=> rdata_o == 16'h0000)
		else $error("unmapped read not zero"); // R24

	abort_seen_c: cover property (early_end ##[1:20] csr_wr && wdata_i[BIT_SETUP_END_ACK]);
	nak_halt_c: cover property (nak_hit);
	error_seen_c: cover property (err_hit);
	stall_seen_c: cover property (cmd_o.stall_go ##[1:10] evt_i.stall_tx);

endmodule : usbep0_ctrl

/* verif/usbep0_link_model.sv */
// usbep0_link_model: protocol engine stand-in that drives link events
`timescale 1ns/1ps

module usbep0_link_model
	import usbep0_pkg::*;
(
	input wire logic sys_clk_i,
	input wire usbep0_cmd_s cmd_i,
	output usbep0_evt_s evt_o
);
	usbep0_evt_s man = '0;
	usbep0_evt_s aut = '0;
	int lat = 1;

	assign evt_o = man | aut;

	// ******************************
	// events on request of the bench
	// ******************************
	task automatic ev(input usbep0_evt_s e);
		@(posedge sys_clk_i);
		man <= e;
		@(posedge sys_clk_i);
		man <= '0;
	endtask : ev

	// ******************************
	// answers to the block's commands
	// ******************************
	always begin
		@(posedge sys_clk_i);
		if (cmd_i.tx_ready === 1'h1 || cmd_i.stall_go === 1'h1) begin
			// lat sets a prompt or a slow bus partner
			repeat (lat) @(posedge sys_clk_i);
			aut.tx_done <= cmd_i.tx_ready;
			aut.stall_tx <= cmd_i.stall_go;
			@(posedge sys_clk_i);
			aut <= '0;
			// let the block drop its command first
			repeat (3) @(posedge sys_clk_i);
		end
	end
endmodule : usbep0_link_model

/* verif/tb_top.sv */
// tb_top: self-checking bench of the endpoint 0 control block
`timescale 1ns/1ps

module tb_top
	import usbep0_pkg::*;
;
	localparam logic [7:0] CS = OFS_EP0_CONTROL_STATUS;
	localparam logic [7:0] MP = OFS_TX_MAX_PACKET;
	localparam logic [7:0] NL = OFS_EP0_NAK_TIMEOUT_LIMIT;
	logic sys_clk_i = 1'h0;
	logic nrst_i = 1'h0;
	logic host_mode_i = 1'h0;
	logic [7:0] addr_i = 8'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'h0;
	logic rd_i = 1'h0;
	logic [15:0] rdata_o;
	usbep0_evt_s evt;
	usbep0_cmd_s cmd_o;
	logic ep0_irq_o;
	int failures = 0;
	int n_tests = 0;
	int irqs = 0;
	int flushes = 0;

	always #5 sys_clk_i = ~sys_clk_i;

	always @(posedge sys_clk_i) begin
		if (ep0_irq_o === 1'h1)
			irqs++;
		if (cmd_o.flush === 1'h1)
			flushes++;
	end

	usbep0_ctrl #(.OPT_HB_TX_ISO(1'h1)) usbep0_ctrl_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
		.host_mode_i(host_mode_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .evt_i(evt), .cmd_o(cmd_o), .ep0_irq_o(ep0_irq_o));
	usbep0_link_model usbep0_link_model_inst (.sys_clk_i(sys_clk_i), .cmd_i(cmd_o), .evt_o(evt));

	// ******************************
	// shared bus and check tasks
	// ******************************
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		wr_i <= 1'h1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
		@(posedge sys_clk_i);
		rd_i <= 1'h1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'h0;
		#1;
		chk(nm, exp, rdata_o);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : idle

	task automatic ev(input usbep0_evt_s e);
		usbep0_link_model_inst.ev(e);
	endtask : ev

	task automatic end_sim();
		if (failures == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// ******************************
	// scenarios
	// ******************************
	task automatic t_reset();
		rd(CS, 16'h0000, "csr");
		rd(OFS_EP0_RX_BYTE_COUNT, 16'h0000, "count");
		rd(OFS_CORE_CONFIG_INFO, 16'h0008, "config");
		wr(OFS_CORE_CONFIG_INFO, 16'hffff);
		rd(OFS_CORE_CONFIG_INFO, 16'h0008, "config ro");
		wr(8'hff, 16'hffff);
		rd(8'hff, 16'h0000, "unmapped");
		wr(CS, 16'hfe00);
		rd(CS, 16'h0000, "unused bits");
	endtask : t_reset

	task automatic t_per_rx();
		int n = irqs;
		ev('{rx_pkt: 1'h1, rx_bytes: 8'h08, default: '0});
		rd(CS, 16'h0001, "rx waiting");
		rd(OFS_EP0_RX_BYTE_COUNT, 16'h0008, "count");
		chk("rx irq", 16'(n + 1), 16'(irqs));
		wr(CS, 16'h0040);
		rd(CS, 16'h0000, "rx ack");
	endtask : t_per_rx

	task automatic t_per_tx();
		int n = irqs;
		usbep0_link_model_inst.lat = 8;
		wr(CS, 16'h0002);
		rd(CS, 16'h0002, "tx loaded");
		idle(12);
		rd(CS, 16'h0000, "tx sent");
		chk("tx irq", 16'(n + 1), 16'(irqs));
	endtask : t_per_tx

	task automatic t_per_stall();
		usbep0_link_model_inst.lat = 1;
		wr(CS, 16'h0020);
		idle(6);
		rd(CS, 16'h0004, "stall sent");
		idle(4);
		rd(CS, 16'h0004, "stall sticky");
		wr(CS, 16'h0000);
		rd(CS, 16'h0000, "stall clear");
	endtask : t_per_stall

	task automatic t_per_abort();
		int n = irqs;
		int f = flushes;
		ev('{rx_pkt: 1'h1, rx_bytes: 8'h04, default: '0});
		ev('{ctrl_end: 1'h1, default: '0});
		rd(CS, 16'h0010, "abort");
		rd(OFS_EP0_RX_BYTE_COUNT, 16'h0000, "abort count");
		chk("abort irq", 16'(n + 2), 16'(irqs));
		wr(CS, 16'h0080);
		rd(CS, 16'h0000, "abort ack");
		ev('{rx_pkt: 1'h1, rx_bytes: 8'h05, default: '0});
		wr(CS, 16'h0048);
		ev('{ctrl_end: 1'h1, default: '0});
		rd(CS, 16'h0000, "normal end");
		ev('{rx_pkt: 1'h1, rx_bytes: 8'h03, default: '0});
		wr(CS, 16'h0100);
		rd(CS, 16'h0000, "flushed");
		rd(OFS_EP0_RX_BYTE_COUNT, 16'h0000, "flush count");
		chk("flushes", 16'(f + 2), 16'(flushes));
	endtask : t_per_abort

	task automatic t_host_in();
		int n;
		@(posedge sys_clk_i);
		host_mode_i <= 1'h1;
		wr(CS, 16'h0060);
		idle(1);
		chk("in cmd", 16'h0003, {14'h0000, cmd_o.in_go, cmd_o.toggle_one});
		n = irqs;
		ev('{rx_pkt: 1'h1, rx_bytes: 8'h02, default: '0});
		rd(CS, 16'h0041, "in done");
		chk("in irq", 16'(n + 1), 16'(irqs));
		wr(CS, 16'h0000);
		rd(CS, 16'h0000, "host clear");
	endtask : t_host_in

	task automatic t_host_out();
		usbep0_link_model_inst.lat = 8;
		wr(CS, 16'h080a);
		idle(1);
		chk("out cmd", 16'h0007, {13'h0000, cmd_o.setup_token, cmd_o.ping_off, cmd_o.tx_ready});
		idle(12);
		rd(CS, 16'h0808, "out sent");
		wr(CS, 16'h0000);
		rd(CS, 16'h0000, "out clear");
	endtask : t_host_out

	task automatic t_host_fail();
		int n = irqs;
		repeat (2) ev('{no_resp: 1'h1, default: '0});
		ev('{resp_ok: 1'h1, default: '0});
		repeat (2) ev('{no_resp: 1'h1, default: '0});
		rd(CS, 16'h0000, "two misses");
		ev('{no_resp: 1'h1, default: '0});
		rd(CS, 16'h0010, "error");
		chk("error irq", 16'(n + 1), 16'(irqs));
		wr(CS, 16'h0000);
		ev('{stall_rx: 1'h1, default: '0});
		idle(5);
		rd(CS, 16'h0004, "stall rx");
		wr(CS, 16'h0000);
		rd(CS, 16'h0000, "fail clear");
	endtask : t_host_fail

	task automatic t_host_nak();
		wr(NL, 16'h0002);
		rd(NL, 16'h0002, "nak limit");
		ev('{nak: 1'h1, default: '0});
		ev('{frame_tick: 1'h1, default: '0});
		rd(CS, 16'h0000, "one frame");
		ev('{nak: 1'h1, default: '0});
		ev('{frame_tick: 1'h1, default: '0});
		rd(CS, 16'h0080, "nak timeout");
		chk("halted", 16'h0001, {15'h0000, cmd_o.halted});
		wr(CS, 16'h0000);
		idle(1);
		chk("resumed", 16'h0000, {15'h0000, cmd_o.halted});
	endtask : t_host_nak

	task automatic t_maxp();
		wr(MP, 16'h0900);
		rd(MP, 16'h0900, "maxp");
		chk("payload", 16'h0100, {5'h00, cmd_o.max_payload});
		chk("mult", 16'h0002, {10'h000, cmd_o.mult});
		wr(MP, 16'hffff);
		rd(MP, 16'hfc00, "maxp clamp");
		chk("payload max", 16'h0400, {5'h00, cmd_o.max_payload});
		chk("mult max", 16'h0020, {10'h000, cmd_o.mult});
		wr(OFS_INDEX, 16'h0001);
		rd(MP, 16'h0000, "other ep");
		wr(MP, 16'h0100);
		wr(OFS_INDEX, 16'h0000);
		rd(MP, 16'hfc00, "ep0 back");
	endtask : t_maxp

	initial begin
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'h1;
		t_reset();
		t_per_rx();
		t_per_tx();
		t_per_stall();
		t_per_abort();
		t_host_in();
		t_host_out();
		t_host_fail();
		t_host_nak();
		t_maxp();
		end_sim();
	end

	initial begin
		#100000;
		failures++;
		end_sim();
	end
endmodule : tb_top
